// ### design/atc_config_bank.sv
/*
 * Tuning configuration register bank for a dual-channel converter,
 * with the two offset correction loops that its fields steer.
 * Assumes the serial port framing delivers one complete byte write
 * as a single-cycle strobe with address and data, synchronous to clock_in.
 */
`timescale 1ns/1ps
module atc_config_bank
	import atc_pkg::*;
(
	// Clock and reset
	input  wire logic              clock_in,
	input  wire logic              rst_b_in,
	// Configuration writes
	input  wire logic              wr_en_in,
	input  wire logic [7:0]        wr_addr_in,
	input  wire logic [7:0]        wr_data_in,
	// Configuration readback
	input  wire logic [7:0]        rd_addr_in,
	output logic      [7:0]        rd_data_out,
	// Samples
	input  wire logic [DATA_W-1:0] chan_a_sample_in,
	input  wire logic [DATA_W-1:0] chan_b_sample_in,
	output logic      [DATA_W-1:0] chan_a_corrected_out,
	output logic      [DATA_W-1:0] chan_b_corrected_out,
	// Analog mode controls
	output logic                   chan_a_fast_input_select_out,
	output logic                   chan_b_fast_input_select_out,
	output logic                   chan_a_slow_enable_out,
	output logic                   chan_b_slow_enable_out,
	output logic                   swing_override_out,
	output logic      [5:0]        swing_code_out,
	output logic      [5:0]        perf_tune_out,
	output logic                   perf_tune_complete_out
);

	typedef struct packed {
		logic [7:0] swing_code_word;
		logic [7:0] perf_tune_word_a;
		logic [7:0] offset_enable_word;
		logic [7:0] digital_enable_word;
		logic [7:0] chan_b_high_freq_ctrl;
		logic [7:0] chan_a_high_freq_ctrl;
		logic [7:0] chan_a_pedestal;
		logic [7:0] chan_b_pedestal;
		logic [7:0] offset_loop_ctrl;
		logic [7:0] perf_tune_word_b;
		logic [7:0] perf_tune_word_c;
		logic [7:0] perf_tune_and_chan_b_slow;
		logic [7:0] slow_mode_gate;
		logic [7:0] swing_override_enable;
		logic [7:0] chan_a_slow_mode;
		logic [7:0] rd_data;
		logic       chan_a_fast_input_select;
		logic       chan_b_fast_input_select;
		logic       chan_a_slow_enable;
		logic       chan_b_slow_enable;
		logic       swing_override;
		logic [5:0] swing_code;
		logic [5:0] perf_tune;
		logic       perf_tune_complete;
		logic       offset_loop_enable;
		logic       offset_estimate_hold;
		logic [3:0] offset_loop_speed;
		logic [3:0] chan_a_target_shift;
		logic [3:0] chan_b_target_shift;
	} atc_bank_type;

	atc_bank_type s;
	atc_bank_type next_s;
	logic [1:0]   rst_sync;
	logic         rst_q_b;

	// Release is synchronised; assertion is still immediate
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end

	assign rst_q_b = rst_sync[1];

	always_comb begin
		next_s = s;
		// Only a whole byte strobe moves a field
		if (wr_en_in) begin
			case (wr_addr_in)
				ADDR_SWING_CODE: begin
					next_s.swing_code_word = wr_data_in & MASK_SWING_CODE;
				end
				ADDR_PERF_A: begin
					next_s.perf_tune_word_a = wr_data_in & MASK_PERF_A;
				end
				ADDR_OFFSET_ENABLE: begin
					next_s.offset_enable_word = wr_data_in & MASK_OFFSET_ENABLE;
				end
				ADDR_DIGITAL_ENABLE: begin
					next_s.digital_enable_word = wr_data_in & MASK_DIGITAL_ENABLE;
				end
				ADDR_CHAN_B_HF: begin
					next_s.chan_b_high_freq_ctrl = wr_data_in & MASK_HF;
				end
				ADDR_CHAN_A_HF: begin
					next_s.chan_a_high_freq_ctrl = wr_data_in & MASK_HF;
				end
				ADDR_CHAN_A_PED: begin
					next_s.chan_a_pedestal = wr_data_in & MASK_PED;
				end
				ADDR_CHAN_B_PED: begin
					next_s.chan_b_pedestal = wr_data_in & MASK_PED;
				end
				ADDR_LOOP_CTRL: begin
					next_s.offset_loop_ctrl = wr_data_in & MASK_LOOP_CTRL;
				end
				ADDR_PERF_B: begin
					next_s.perf_tune_word_b = wr_data_in & MASK_PERF_B;
				end
				ADDR_PERF_C: begin
					next_s.perf_tune_word_c = wr_data_in & MASK_PERF_C;
				end
				ADDR_PERF_SLOW_B: begin
					next_s.perf_tune_and_chan_b_slow = wr_data_in & MASK_PERF_SLOW_B;
				end
				ADDR_SLOW_GATE: begin
					next_s.slow_mode_gate = wr_data_in & MASK_SLOW_GATE;
				end
				ADDR_SWING_ENABLE: begin
					next_s.swing_override_enable = wr_data_in & MASK_SWING_ENABLE;
				end
				ADDR_CHAN_A_SLOW: begin
					next_s.chan_a_slow_mode = wr_data_in & MASK_CHAN_A_SLOW;
				end
				default: begin
					// Unmapped offsets are ignored
				end
			endcase
		end

		// Controls follow the new register values on the same edge
		next_s.chan_a_fast_input_select = next_s.chan_a_high_freq_ctrl[BIT_HF];
		next_s.chan_b_fast_input_select = next_s.chan_b_high_freq_ctrl[BIT_HF];
		next_s.chan_a_slow_enable = next_s.slow_mode_gate[BIT_SLOW_GATE]
			&& next_s.chan_a_slow_mode[BIT_SLOW_A];
		next_s.chan_b_slow_enable = next_s.slow_mode_gate[BIT_SLOW_GATE]
			&& next_s.perf_tune_and_chan_b_slow[BIT_SLOW_B];
		// Reserved codes 01 and 10 leave the override off
		next_s.swing_override = next_s.swing_override_enable[1:0] == SWING_ON;
		next_s.swing_code = next_s.swing_code_word[SWING_LSB +: 6];
		next_s.perf_tune = {next_s.perf_tune_and_chan_b_slow[BIT_PERF_8],
			next_s.perf_tune_word_c[BIT_PERF_7],
			next_s.perf_tune_word_c[BIT_PERF_6],
			next_s.perf_tune_word_b[BIT_PERF_5],
			next_s.perf_tune_word_b[BIT_PERF_4],
			next_s.perf_tune_word_a[BIT_PERF_3]};
		next_s.perf_tune_complete = &next_s.perf_tune;
		// Loop runs only with both enables; freeze without them is moot
		next_s.offset_loop_enable = next_s.offset_enable_word[BIT_LOOP_EN]
			&& next_s.digital_enable_word[BIT_DIGITAL_EN];
		next_s.offset_estimate_hold = next_s.offset_loop_ctrl[BIT_HOLD];
		next_s.offset_loop_speed = next_s.offset_loop_ctrl[SPEED_LSB +: 4];
		next_s.chan_a_target_shift = next_s.chan_a_pedestal[PED_LSB +: 4];
		next_s.chan_b_target_shift = next_s.chan_b_pedestal[PED_LSB +: 4];

		// Readback shows stored state, one cycle after the address
		case (rd_addr_in)
			ADDR_SWING_CODE:     next_s.rd_data = s.swing_code_word;
			ADDR_PERF_A:         next_s.rd_data = s.perf_tune_word_a;
			ADDR_OFFSET_ENABLE:  next_s.rd_data = s.offset_enable_word;
			ADDR_DIGITAL_ENABLE: next_s.rd_data = s.digital_enable_word;
			ADDR_CHAN_B_HF:      next_s.rd_data = s.chan_b_high_freq_ctrl;
			ADDR_CHAN_A_HF:      next_s.rd_data = s.chan_a_high_freq_ctrl;
			ADDR_CHAN_A_PED:     next_s.rd_data = s.chan_a_pedestal;
			ADDR_CHAN_B_PED:     next_s.rd_data = s.chan_b_pedestal;
			ADDR_LOOP_CTRL:      next_s.rd_data = s.offset_loop_ctrl;
			ADDR_PERF_B:         next_s.rd_data = s.perf_tune_word_b;
			ADDR_PERF_C:         next_s.rd_data = s.perf_tune_word_c;
			ADDR_PERF_SLOW_B:    next_s.rd_data = s.perf_tune_and_chan_b_slow;
			ADDR_SLOW_GATE:      next_s.rd_data = s.slow_mode_gate;
			ADDR_SWING_ENABLE:   next_s.rd_data = s.swing_override_enable;
			ADDR_CHAN_A_SLOW:    next_s.rd_data = s.chan_a_slow_mode;
			default:             next_s.rd_data = RESET_BYTE;
		endcase
	end

	always_ff @(posedge clock_in or negedge rst_q_b) begin
		if (!rst_q_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	atc_offset_loop u_chan_a_loop (
		.clock_in       (clock_in),
		.rst_b_in       (rst_q_b),
		.loop_enable_in (s.offset_loop_enable),
		.hold_in        (s.offset_estimate_hold),
		.speed_in       (s.offset_loop_speed),
		.shift_in       (s.chan_a_target_shift),
		.sample_in      (chan_a_sample_in),
		.corrected_out  (chan_a_corrected_out)
	);

	atc_offset_loop u_chan_b_loop (
		.clock_in       (clock_in),
		.rst_b_in       (rst_q_b),
		.loop_enable_in (s.offset_loop_enable),
		.hold_in        (s.offset_estimate_hold),
		.speed_in       (s.offset_loop_speed),
		.shift_in       (s.chan_b_target_shift),
		.sample_in      (chan_b_sample_in),
		.corrected_out  (chan_b_corrected_out)
	);

	assign rd_data_out                  = s.rd_data;
	assign chan_a_fast_input_select_out = s.chan_a_fast_input_select;
	assign chan_b_fast_input_select_out = s.chan_b_fast_input_select;
	assign chan_a_slow_enable_out       = s.chan_a_slow_enable;
	assign chan_b_slow_enable_out       = s.chan_b_slow_enable;
	assign swing_override_out           = s.swing_override;
	assign swing_code_out               = s.swing_code;
	assign perf_tune_out                = s.perf_tune;
	assign perf_tune_complete_out       = s.perf_tune_complete;

	chk_fast_b_write: assert property (@(posedge clock_in) disable iff (!rst_q_b)
		wr_en_in && wr_addr_in == ADDR_CHAN_B_HF
		|=> chan_b_fast_input_select_out == $past(wr_data_in[BIT_HF]))
		else $error("channel B fast select did not follow write");

	chk_fast_a_write: assert property (@(posedge clock_in) disable iff (!rst_q_b)
		wr_en_in && wr_addr_in == ADDR_CHAN_A_HF
		|=> chan_a_fast_input_select_out == $past(wr_data_in[BIT_HF]))
		else $error("channel A fast select did not follow write");

	chk_ped_a_store: assert property (@(posedge clock_in) disable iff (!rst_q_b)
		wr_en_in && wr_addr_in == ADDR_CHAN_A_PED
		|=> s.chan_a_target_shift == $past(wr_data_in[7:4]) ##1 rd_data_out[7:4] ==
		$past(s.chan_a_target_shift) || $past(rd_addr_in) != ADDR_CHAN_A_PED)
		else $error("channel A pedestal not stored");

	chk_ped_b_store: assert property (@(posedge clock_in) disable iff (!rst_q_b)
		wr_en_in && wr_addr_in == ADDR_CHAN_B_PED
		|=> s.chan_b_target_shift == $past(wr_data_in[7:4]))
		else $error("channel B pedestal not stored");

	chk_ped_independent: assert property (@(posedge clock_in) disable iff (!rst_q_b)
		wr_en_in && wr_addr_in == ADDR_CHAN_A_PED |=> $stable(s.chan_b_target_shift))
		else $error("channel A write disturbed channel B pedestal");

	chk_hold_follows: assert property (@(posedge clock_in) disable iff (!rst_q_b)
		wr_en_in && wr_addr_in == ADDR_LOOP_CTRL
		|=> s.offset_estimate_hold == $past(wr_data_in[BIT_HOLD]))
		else $error("freeze bit not applied");

	chk_speed_field: assert property (@(posedge clock_in) disable iff (!rst_q_b)
		wr_en_in && wr_addr_in == ADDR_LOOP_CTRL
		|=> s.offset_loop_speed == $past(wr_data_in[5:2]))
		else $error("time constant field not applied");

	chk_slow_gate_off: assert property (@(posedge clock_in) disable iff (!rst_q_b)
		!s.slow_mode_gate[BIT_SLOW_GATE] |-> !chan_a_slow_enable_out && !chan_b_slow_enable_out)
		else $error("low-speed mode active without gate");

	chk_slow_a_gated: assert property (@(posedge clock_in) disable iff (!rst_q_b)
		chan_a_slow_enable_out == (s.slow_mode_gate[BIT_SLOW_GATE] && s.chan_a_slow_mode[BIT_SLOW_A]))
		else $error("channel A low-speed mismatch");

	chk_slow_b_gated: assert property (@(posedge clock_in) disable iff (!rst_q_b)
		chan_b_slow_enable_out ==
		(s.slow_mode_gate[BIT_SLOW_GATE] && s.perf_tune_and_chan_b_slow[BIT_SLOW_B]))
		else $error("channel B low-speed mismatch");

	chk_swing_code_11: assert property (@(posedge clock_in) disable iff (!rst_q_b)
		swing_override_out == (s.swing_override_enable[1:0] == SWING_ON))
		else $error("swing override on a reserved code");

	chk_reset_clear: assert property (@(posedge clock_in)
		!rst_q_b |-> s == '0)
		else $error("bank not cleared in reset");

	chk_loop_both_en: assert property (@(posedge clock_in) disable iff (!rst_q_b)
		s.offset_loop_enable == (s.offset_enable_word[BIT_LOOP_EN]
		&& s.digital_enable_word[BIT_DIGITAL_EN]))
		else $error("loop enable not gated by both bits");

	chk_quiet_no_write: assert property (@(posedge clock_in) disable iff (!rst_q_b)
		!wr_en_in |=> $stable(s.offset_loop_ctrl) && $stable(s.chan_a_pedestal)
		&& $stable(s.swing_override_enable) && $stable(s.slow_mode_gate))
		else $error("field changed without a write");

	cov_perf_complete: cover property (@(posedge clock_in) disable iff (!rst_q_b)
		$rose(perf_tune_complete_out));
	cov_frozen_loop: cover property (@(posedge clock_in) disable iff (!rst_q_b)
		s.offset_loop_enable && s.offset_estimate_hold);
	cov_swing_on: cover property (@(posedge clock_in) disable iff (!rst_q_b)
		$rose(swing_override_out));
	cov_slow_both: cover property (@(posedge clock_in) disable iff (!rst_q_b)
		chan_a_slow_enable_out && chan_b_slow_enable_out);
	cov_ped_split: cover property (@(posedge clock_in) disable iff (!rst_q_b)
		s.chan_a_target_shift[3] != s.chan_b_target_shift[3]);

endmodule

// ### design/atc_offset_loop.sv
/*
 * One channel of the offset correction loop: subtracts a running
 * estimate from each sample and steers the result toward midcode plus
 * a signed pedestal.
 * Assumes one sample per clock, offset binary, and a synchronised reset.
 */
`timescale 1ns/1ps
module atc_offset_loop
	import atc_pkg::*;
(
	// Clock and reset
	input  wire logic              clock_in,
	input  wire logic              rst_b_in,
	// Controls
	input  wire logic              loop_enable_in,
	input  wire logic              hold_in,
	input  wire logic [3:0]        speed_in,
	input  wire logic [3:0]        shift_in,
	// Samples
	input  wire logic [DATA_W-1:0] sample_in,
	output logic      [DATA_W-1:0] corrected_out
);

	typedef struct packed {
		logic signed [ACC_W-1:0] acc;
		logic [DATA_W-1:0]       corrected;
	} atc_loop_type;

	atc_loop_type        s;
	atc_loop_type        next_s;
	logic signed [13:0]  est_int;
	logic signed [14:0]  diff;
	logic [DATA_W-1:0]   clipped;
	logic signed [14:0]  target;
	logic signed [14:0]  err;
	logic [4:0]          shamt;
	logic signed [ACC_W-1:0] step;

	always_comb begin
		next_s = s;
		est_int = s.acc[ACC_W-1:FRAC_W];
		diff = $signed({3'b000, sample_in}) - $signed({est_int[13], est_int});
		if (diff < 0) begin
			clipped = '0;
		end else if (diff > $signed({3'b000, {DATA_W{1'b1}}})) begin
			clipped = '1;
		end else begin
			clipped = diff[DATA_W-1:0];
		end
		// Signed pedestal sits on midcode
		target = $signed({3'b000, MIDCODE}) + $signed({{11{shift_in[3]}}, shift_in});
		err = $signed({3'b000, clipped}) - target;
		// Larger time constant, smaller step; speed 0 settles in one step
		shamt = 5'(FRAC_W) - {1'b0, speed_in};
		step = $signed({{(ACC_W-15){err[14]}}, err}) <<< shamt;
		if (loop_enable_in) begin
			next_s.corrected = clipped;
			if (!hold_in) begin
				next_s.acc = s.acc + step;
			end
		end else begin
			// Estimate dropped so a re-enable starts clean
			next_s.acc = '0;
			next_s.corrected = sample_in;
		end
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign corrected_out = s.corrected;

	chk_hold_keeps_est: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		loop_enable_in && hold_in |=> $stable(s.acc))
		else $error("estimate moved while held");

	chk_loop_settles_target: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		(loop_enable_in && !hold_in && speed_in == 4'h0 && diff >= 0 && diff <= 15'sd4095)
		##1 (loop_enable_in && !hold_in && $stable(sample_in) && $stable(shift_in))
		|=> corrected_out == $past(target[DATA_W-1:0], 2))
		else $error("corrected output missed midcode plus pedestal");

	chk_bypass_raw: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		!loop_enable_in |=> corrected_out == $past(sample_in) && s.acc == '0)
		else $error("disabled loop altered the sample");

endmodule

// ### design/atc_pkg.sv
/*
 * Constants for the converter tuning configuration bank: register
 * offsets, writable-bit masks, field positions, reset value and the
 * offset loop arithmetic widths.
 * Assumes an 8-bit address, 8-bit data write port already decoded
 * from the serial configuration frame.
 */
// How it works
// - Register 4Ah bit 0 selects channel B high-frequency mode, default off.
// - Register 58h bit 0 selects channel A high-frequency mode, default off.
// - With offset loop on, each corrected output settles at midcode plus pedestal.
// - Register Chan_a_pedestal bits 7..4 hold the channel A pedestal.
// - Register C1h bits 7..4 hold the channel B pedestal, independent of A.
// - Pedestal fields are signed four-bit values, -8 to +7 around midcode.
// - Writing one channel's pedestal leaves the other channel's pedestal untouched.
// - Register Offset_loop_ctrl bit 7 freezes the estimate; last estimate keeps being applied.
// - Register Offset_loop_ctrl bits 5..2 set the offset loop time constant.
// - Register Slow_mode_gate bit 4 gates low-speed mode; zero forces it off.
// - Register F2h bit 3 enables channel A low-speed mode under the gate.
// - Register Perf_tune_and_chan_b_slow bit 0 enables channel B low-speed mode under the gate.
// - Register F1h bits 1..0 enable swing override only when both set.
// - Every register of the bank resets to 00h.
// - Register 3Dh bit 5 enables the offset loop.
// - Register 42h bit 3 enables digital functions, offset loop included.
package atc_pkg;

	localparam int          DATA_W     = 12;
	localparam int          FRAC_W     = 16;
	localparam int          ACC_W      = 30;
	localparam logic [11:0] MIDCODE    = 12'h800;
	localparam logic [7:0]  RESET_BYTE = 8'h00;

	// Register offsets
	localparam logic [7:0] ADDR_SWING_CODE     = 8'h01;
	localparam logic [7:0] ADDR_PERF_A         = 8'h02;
	localparam logic [7:0] ADDR_OFFSET_ENABLE  = 8'h3d;
	localparam logic [7:0] ADDR_DIGITAL_ENABLE = 8'h42;
	localparam logic [7:0] ADDR_CHAN_B_HF      = 8'h4a;
	localparam logic [7:0] ADDR_CHAN_A_HF      = 8'h58;
	localparam logic [7:0] ADDR_CHAN_A_PED     = 8'hbf;
	localparam logic [7:0] ADDR_CHAN_B_PED     = 8'hc1;
	localparam logic [7:0] ADDR_LOOP_CTRL      = 8'hcf;
	localparam logic [7:0] ADDR_PERF_B         = 8'hd5;
	localparam logic [7:0] ADDR_PERF_C         = 8'hd7;
	localparam logic [7:0] ADDR_PERF_SLOW_B    = 8'hdb;
	localparam logic [7:0] ADDR_SLOW_GATE      = 8'hef;
	localparam logic [7:0] ADDR_SWING_ENABLE   = 8'hf1;
	localparam logic [7:0] ADDR_CHAN_A_SLOW    = 8'hf2;

	// Writable bits; the rest store nothing and read zero
	localparam logic [7:0] MASK_SWING_CODE     = 8'hfc;
	localparam logic [7:0] MASK_PERF_A         = 8'h40;
	localparam logic [7:0] MASK_OFFSET_ENABLE  = 8'h20;
	localparam logic [7:0] MASK_DIGITAL_ENABLE = 8'h08;
	localparam logic [7:0] MASK_HF             = 8'h01;
	localparam logic [7:0] MASK_PED            = 8'hf0;
	localparam logic [7:0] MASK_LOOP_CTRL      = 8'hbc;
	localparam logic [7:0] MASK_PERF_B         = 8'h18;
	localparam logic [7:0] MASK_PERF_C         = 8'h0c;
	localparam logic [7:0] MASK_PERF_SLOW_B    = 8'h21;
	localparam logic [7:0] MASK_SLOW_GATE      = 8'h10;
	localparam logic [7:0] MASK_SWING_ENABLE   = 8'h03;
	localparam logic [7:0] MASK_CHAN_A_SLOW    = 8'h08;

	// Field positions
	localparam int BIT_HF          = 0;
	localparam int PED_LSB         = 4;
	localparam int BIT_HOLD        = 7;
	localparam int SPEED_LSB       = 2;
	localparam int BIT_LOOP_EN     = 5;
	localparam int BIT_DIGITAL_EN  = 3;
	localparam int BIT_SLOW_GATE   = 4;
	localparam int BIT_SLOW_A      = 3;
	localparam int BIT_SLOW_B      = 0;
	localparam int SWING_LSB       = 2;
	localparam int BIT_PERF_3      = 6;
	localparam int BIT_PERF_4      = 4;
	localparam int BIT_PERF_5      = 3;
	localparam int BIT_PERF_6      = 3;
	localparam int BIT_PERF_7      = 2;
	localparam int BIT_PERF_8      = 5;
	localparam logic [1:0] SWING_ON = 2'b11;

endpackage

// ### test/atc_host_model.sv
/*
 * Host controller model for the configuration write port.
 * Assumes the bench calls write_reg one write at a time.
 */
`timescale 1ns/1ps
module atc_host_model (
	// Clock
	input  wire logic       clock_in,
	// Write port
	output logic            wr_en_out,
	output logic      [7:0] wr_addr_out,
	output logic      [7:0] wr_data_out
);
	initial begin
		wr_en_out   = 1'b0;
		wr_addr_out = 8'h00;
		wr_data_out = 8'h00;
	end

	// Whole byte per strobe, launched on the falling edge
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(negedge clock_in);
		wr_en_out   = 1'b1;
		wr_addr_out = addr;
		wr_data_out = data;
		@(negedge clock_in);
		wr_en_out   = 1'b0;
		// Released lines flip so a stale byte is never mistaken for live
		wr_addr_out = ~addr;
		wr_data_out = ~data;
	endtask
endmodule

// ### test/test_adc_tuning_config_registers.sv
/*
 * Self-checking bench for the tuning configuration bank.
 * Assumes the host model as write source and a 50 MHz clock.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
$display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module test_adc_tuning_config_registers
	import atc_pkg::*;
;
	logic        clock_in, rst_b_in, wr_en, fa, fb, sa, sb, sw, pc;
	logic [7:0]  wr_addr, wr_data, rd_addr, rd_data, v;
	logic [7:0]  shadow [256];
	logic [11:0] samp_a, samp_b, corr_a, corr_b;
	logic [5:0]  swc, pt;
	int          err_count, checked, seed;
	logic [7:0]  addrs [15] = '{ADDR_SWING_CODE, ADDR_PERF_A, ADDR_OFFSET_ENABLE,
		ADDR_DIGITAL_ENABLE, ADDR_CHAN_B_HF, ADDR_CHAN_A_HF, ADDR_CHAN_A_PED, ADDR_CHAN_B_PED,
		ADDR_LOOP_CTRL, ADDR_PERF_B, ADDR_PERF_C, ADDR_PERF_SLOW_B, ADDR_SLOW_GATE,
		ADDR_SWING_ENABLE, ADDR_CHAN_A_SLOW};
	logic [7:0]  masks [15] = '{MASK_SWING_CODE, MASK_PERF_A, MASK_OFFSET_ENABLE,
		MASK_DIGITAL_ENABLE, MASK_HF, MASK_HF, MASK_PED, MASK_PED, MASK_LOOP_CTRL,
		MASK_PERF_B, MASK_PERF_C, MASK_PERF_SLOW_B, MASK_SLOW_GATE, MASK_SWING_ENABLE,
		MASK_CHAN_A_SLOW};

	atc_host_model i_atc_host_model (.clock_in(clock_in), .wr_en_out(wr_en),
		.wr_addr_out(wr_addr), .wr_data_out(wr_data));

	atc_config_bank i_atc_config_bank (.clock_in(clock_in), .rst_b_in(rst_b_in),
		.wr_en_in(wr_en), .wr_addr_in(wr_addr), .wr_data_in(wr_data),
		.rd_addr_in(rd_addr), .rd_data_out(rd_data),
		.chan_a_sample_in(samp_a), .chan_b_sample_in(samp_b),
		.chan_a_corrected_out(corr_a), .chan_b_corrected_out(corr_b),
		.chan_a_fast_input_select_out(fa), .chan_b_fast_input_select_out(fb),
		.chan_a_slow_enable_out(sa), .chan_b_slow_enable_out(sb),
		.swing_override_out(sw), .swing_code_out(swc),
		.perf_tune_out(pt), .perf_tune_complete_out(pc));

	initial begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end

	function automatic logic [5:0] perf_exp();
		return {shadow[8'hdb][5], shadow[8'hd7][2], shadow[8'hd7][3],
			shadow[8'hd5][3], shadow[8'hd5][4], shadow[8'h02][6]};
	endfunction

	// Host keeps reserved bits zero, legal override codes, loop enable on
	function automatic logic [7:0] host_byte(input int i, input logic [7:0] d);
		logic [7:0] b;
		b = d & masks[i];
		if (addrs[i] == ADDR_SWING_ENABLE) b = {8{d[0]}} & masks[i];
		if (addrs[i] == ADDR_OFFSET_ENABLE) b = MASK_OFFSET_ENABLE;
		return b;
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_atc_host_model.write_reg(a, d);
		shadow[a] = d;
	endtask

	// Registered readback: address on one fall, data by the next
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock_in);
		rd_addr = a;
		@(negedge clock_in);
		d = rd_data;
	endtask

	task automatic chk_outs();
		`CHK(fa, shadow[8'h58][0])
		`CHK(fb, shadow[8'h4a][0])
		`CHK(sa, shadow[8'hef][4] & shadow[8'hf2][3])
		`CHK(sb, shadow[8'hef][4] & shadow[8'hdb][0])
		`CHK(sw, &shadow[8'hf1][1:0])
		`CHK(swc, shadow[8'h01][7:2])
		`CHK(pt, perf_exp())
		`CHK(pc, &perf_exp())
	endtask

	task automatic chk_corr(input logic [11:0] ea, input logic [11:0] eb);
		`CHK(corr_a, ea)
		`CHK(corr_b, eb)
	endtask

	task automatic print_verdict();
		if (err_count == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		seed = 32'h1a4a;
		err_count = 0;
		checked = 0;
		rd_addr = 8'h00;
		samp_a = 12'h900;
		samp_b = 12'h900;
		rst_b_in = 1'b0;
		foreach (shadow[i]) shadow[i] = 8'h00;
		repeat (6) @(negedge clock_in);
		rst_b_in = 1'b1;
		repeat (3) @(negedge clock_in);
		`CHK(corr_a, samp_a)
		for (int i = 0; i < 15; i++) begin
			rd(addrs[i], v);
			`CHK(v, 8'h00)
		end
		chk_outs();
		// Random contents; gate and override set first, override then toggles
		for (int r = 0; r < 4; r++) begin
			wr(ADDR_SLOW_GATE, MASK_SLOW_GATE);
			wr(ADDR_SWING_ENABLE, {6'h00, SWING_ON});
			for (int i = 0; i < 15; i++) wr(addrs[i], host_byte(i, 8'($random(seed))));
			wr(ADDR_SWING_ENABLE, (r % 2 == 1) ? {6'h00, SWING_ON} : 8'h00);
			for (int i = 0; i < 15; i++) begin
				rd(addrs[i], v);
				`CHK(v, shadow[addrs[i]] & masks[i])
			end
			chk_outs();
		end
		wr(8'h03, 8'h03);
		rd(8'h03, v);
		`CHK(v, 8'h00)
		wr(ADDR_SLOW_GATE, MASK_SLOW_GATE);
		wr(ADDR_PERF_A, MASK_PERF_A);
		wr(ADDR_PERF_B, MASK_PERF_B);
		wr(ADDR_PERF_C, MASK_PERF_C);
		wr(ADDR_PERF_SLOW_B, MASK_PERF_SLOW_B);
		chk_outs();
		wr(ADDR_CHAN_A_PED, 8'h70);
		wr(ADDR_CHAN_B_PED, 8'h80);
		rd(ADDR_CHAN_A_PED, v);
		`CHK(v, 8'h70)
		// Loop converges at full step; enable kept set around the freeze
		wr(ADDR_LOOP_CTRL, 8'h00);
		wr(ADDR_OFFSET_ENABLE, 8'h20);
		wr(ADDR_DIGITAL_ENABLE, 8'h08);
		repeat (10) @(negedge clock_in);
		chk_corr(12'h807, 12'h7f8);
		wr(ADDR_LOOP_CTRL, 8'h80);
		samp_a = 12'h910;
		samp_b = 12'h910;
		repeat (4) @(negedge clock_in);
		chk_corr(12'h817, 12'h808);
		wr(ADDR_LOOP_CTRL, 8'h00);
		repeat (10) @(negedge clock_in);
		chk_corr(12'h807, 12'h7f8);
		wr(ADDR_OFFSET_ENABLE, 8'h00);
		repeat (3) @(negedge clock_in);
		`CHK(corr_a, 12'h910)
		wr(ADDR_OFFSET_ENABLE, 8'h20);
		wr(ADDR_DIGITAL_ENABLE, 8'h00);
		repeat (3) @(negedge clock_in);
		`CHK(corr_b, 12'h910)
		print_verdict();
	end

	// Whole run takes well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clock_in);
		err_count++;
		print_verdict();
	end
endmodule
